// ### logic/burst_sram_pkg.sv
// shared widths, reset values and carrier structs for the burst sram port
// assumes one clock; both data edges of a cycle travel side by side as rise/fall
package burst_sram_pkg;

    localparam int WORD_W     = 18;              // 18 or 36, nine bits per byte lane
    localparam int LANE_W     = 9;
    localparam int LANES      = WORD_W / LANE_W;
    localparam int ADDR_W     = 10;
    localparam int PAIR_STEP  = 2;               // second pair of a burst starts at a+2
    localparam int READ_LAT   = 2;               // cycles from read start to first data
    localparam logic RST_OE   = 1'b0;            // deselected, outputs floating
    localparam logic RST_FLAG = 1'b0;

    typedef struct packed {
        logic              read_port_select_n;
        logic              write_port_select_n;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic [WORD_W-1:0] d_rise;
        logic [WORD_W-1:0] d_fall;
        logic [LANES-1:0]  byte_write_select_n_rise;
        logic [LANES-1:0]  byte_write_select_n_fall;
    } wdata_t;

    typedef struct packed {
        logic [WORD_W-1:0] q_rise;
        logic [WORD_W-1:0] q_fall;
        logic              q_oe;
        logic              valid_rise;
        logic              valid_fall;
    } rdata_t;

endpackage

// ### logic/burst_pair_mem.sv
// array of words, two byte-masked write ports and two read ports
// read data come out of a register one cycle after the address
`timescale 1ns/100ps

module burst_pair_mem #(
    parameter int WORD_W = 18,
    parameter int LANES  = 2,
    parameter int ADDR_W = 10
) (
    input  wire logic              clock,
    input  wire logic [ADDR_W-1:0] waddr_a,
    input  wire logic [ADDR_W-1:0] waddr_b,
    input  wire logic [WORD_W-1:0] wdata_a,
    input  wire logic [WORD_W-1:0] wdata_b,
    input  wire logic [LANES-1:0]  we_a,
    input  wire logic [LANES-1:0]  we_b,
    input  wire logic [ADDR_W-1:0] raddr_a,
    input  wire logic [ADDR_W-1:0] raddr_b,
    output logic      [WORD_W-1:0] rdata_a,
    output logic      [WORD_W-1:0] rdata_b
);

    localparam int LANE_W = WORD_W / LANES;

    logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

    function automatic logic [WORD_W-1:0] lane_mask(input logic [LANES-1:0] we);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{we[i]}};
        end
        return m;
    endfunction

    // port b follows port a, so b wins when a burst wraps onto itself
    always_ff @(posedge clock) begin
        mem[waddr_a] <= (mem[waddr_a] & ~lane_mask(we_a)) | (wdata_a & lane_mask(we_a));
        mem[waddr_b] <= (mem[waddr_b] & ~lane_mask(we_b)) | (wdata_b & lane_mask(we_b));
        rdata_a      <= mem[raddr_a];
        rdata_b      <= mem[raddr_b];
    end

endmodule

// ### logic/burst_sram_port.sv
// device side of a burst-of-four sram with separate read and write ports
// assumes the controller runs on the same clock; each cycle carries the word of
// the positive edge (rise) and of the complementary edge (fall) side by side
`timescale 1ns/100ps

// Functional notes
// [R01] write starts on low write select; words a,a+1 next cycle, a+2,a+3 after
// [R02] read starts on low read select; data pairs appear in cycles t+2 and t+3
// [R03] with clocks stopped every input and output register keeps its state
// [R04] after reset the port is deselected and outputs float
// [R05] burst words use latched address and the three following addresses
// [R06] write data taken on both edges, read data given on both edges
// [R07] controller should park both clocks high when stopping them
// [R08] a select that started last cycle's operation is ignored this cycle
// [R09] second read or write on consecutive cycles is ignored
// [R10] 18-bit: select 0 gates bits 8:0, select 1 gates bits 17:9
// [R11] 18-bit: both selects high writes nothing for that word
// [R12] 36-bit: four selects gate the four nine-bit lanes
// [R13] 36-bit: all selects high writes no byte of that word
// [R14] controller may change byte selects on every data edge
// [R15] after a deselect the pending read finishes, then outputs float
// [R16] both selects low: idle gives read, after read write, after write read
// [R17] output valid indicator leads valid read data by half a cycle
module burst_sram_port
    import burst_sram_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rstn,
    input  wire cmd_t   cmd,
    input  wire wdata_t wdata,
    output rdata_t      rdata
);

    // ---------------------------------------------------------------
    // command acceptance
    // ---------------------------------------------------------------
    logic              rd1_reg, rd1_next;   // cycle t+1 of a read
    logic              rd2_reg, rd2_next;   // cycle t+2 of a read
    logic              rd3_reg, rd3_next;   // cycle t+3 of a read
    logic              wr1_reg, wr1_next;   // first data cycle of a write
    logic              wr2_reg, wr2_next;   // second data cycle of a write
    logic [ADDR_W-1:0] raddr_reg, raddr_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic              start_rd;
    logic              start_wr;

    always_comb begin
        // a busy port treats its select as don't-care
        start_rd = !cmd.read_port_select_n && !rd1_reg;                       // R08 R09
        // read wins a tie unless a read started last cycle, which rd1 blocks
        start_wr = !cmd.write_port_select_n && !wr1_reg && !start_rd;         // R09 R16
        rd1_next   = start_rd;                                                // R02
        rd2_next   = rd1_reg;
        rd3_next   = rd2_reg;
        wr1_next   = start_wr;                                                // R01
        wr2_next   = wr1_reg;
        raddr_next = start_rd ? cmd.addr : raddr_reg;                         // R05
        waddr_next = start_wr ? cmd.addr : waddr_reg;                         // R05
    end

    // registers only move on clock edges, so a stopped clock freezes them all
    always_ff @(posedge clock) begin                                          // R03
        if (!rstn) begin
            rd1_reg   <= RST_FLAG;                                            // R04
            rd2_reg   <= RST_FLAG;
            rd3_reg   <= RST_FLAG;
            wr1_reg   <= RST_FLAG;
            wr2_reg   <= RST_FLAG;
            raddr_reg <= '0;
            waddr_reg <= '0;
        end else begin
            rd1_reg   <= rd1_next;
            rd2_reg   <= rd2_next;
            rd3_reg   <= rd3_next;
            wr1_reg   <= wr1_next;
            wr2_reg   <= wr2_next;
            raddr_reg <= raddr_next;
            waddr_reg <= waddr_next;
        end
    end

    // ---------------------------------------------------------------
    // array access
    // ---------------------------------------------------------------
    logic [ADDR_W-1:0] mem_waddr;
    logic [ADDR_W-1:0] mem_raddr;
    logic [LANES-1:0]  we_rise;
    logic [LANES-1:0]  we_fall;
    logic [WORD_W-1:0] mem_q_rise;
    logic [WORD_W-1:0] mem_q_fall;
    logic              wr_active;

    always_comb begin
        wr_active = wr1_reg || wr2_reg;
        // data of a write phase sits on the pins in the cycle it is written
        mem_waddr = wr2_reg ? waddr_reg + ADDR_W'(PAIR_STEP) : waddr_reg;     // R01 R05
        // selects are active low and sampled per edge; all high writes nothing
        we_rise   = wr_active ? ~wdata.byte_write_select_n_rise : '0;         // R10 R12 R11 R13
        we_fall   = wr_active ? ~wdata.byte_write_select_n_fall : '0;         // R06 R14
        // first pair is looked up on the start cycle, second pair one later
        mem_raddr = start_rd ? cmd.addr : raddr_reg + ADDR_W'(PAIR_STEP);     // R05
    end

    burst_pair_mem #(
        .WORD_W (WORD_W),
        .LANES  (LANES),
        .ADDR_W (ADDR_W)
    ) burst_pair_mem_inst (
        .clock   (clock),
        .waddr_a (mem_waddr),
        .waddr_b (mem_waddr + ADDR_W'(1)),
        .wdata_a (wdata.d_rise),
        .wdata_b (wdata.d_fall),
        .we_a    (we_rise),
        .we_b    (we_fall),
        .raddr_a (mem_raddr),
        .raddr_b (mem_raddr + ADDR_W'(1)),
        .rdata_a (mem_q_rise),
        .rdata_b (mem_q_fall)
    );

    // ---------------------------------------------------------------
    // output stage
    // ---------------------------------------------------------------
    rdata_t out_reg, out_next;

    always_comb begin
        out_next = out_reg;
        // array data is one cycle old, so loading in t+1 and t+2 lands in t+2, t+3
        if (rd1_reg || rd2_reg) begin                                         // R02 R06
            out_next.q_rise = mem_q_rise;
            out_next.q_fall = mem_q_fall;
        end
        // float again right after the last pair of a finished read
        out_next.q_oe       = rd1_reg || rd2_reg;                             // R15
        // fall half of t+1 through rise half of t+3: half a cycle ahead of data
        out_next.valid_fall = start_rd || rd1_reg;                            // R17
        out_next.valid_rise = rd1_reg || rd2_reg;                             // R17
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            out_reg.q_rise     <= '0;
            out_reg.q_fall     <= '0;
            out_reg.q_oe       <= RST_OE;                                     // R04
            out_reg.valid_rise <= RST_FLAG;
            out_reg.valid_fall <= RST_FLAG;
        end else begin
            out_reg <= out_next;
        end
    end

    assign rdata = out_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_read_latency: assert property (@(posedge clock) disable iff (!rstn)    // R02
        start_rd |-> ##2 (out_reg.q_oe && out_reg.valid_rise) ##1 out_reg.q_oe)
        else $error("read data not driven in cycles t+2 and t+3");

    // a read started two cycles later looks its first pair up from the pins instead
    a_read_data: assert property (@(posedge clock) disable iff (!rstn)       // R05
        rd1_reg |=> (out_reg.q_rise == $past(mem_q_rise))
        && (start_rd || mem_raddr == $past(raddr_reg) + ADDR_W'(PAIR_STEP)))
        else $error("second read pair not taken from a+2");

    a_fall_pair: assert property (@(posedge clock) disable iff (!rstn)       // R06
        rd2_reg |=> (out_reg.q_fall == $past(mem_q_fall)))
        else $error("fall word of second pair not taken from the array");

    a_read_addr: assert property (@(posedge clock) disable iff (!rstn)       // R05
        start_rd |=> (raddr_reg == $past(cmd.addr)))
        else $error("read start address not latched");

    a_write_addr: assert property (@(posedge clock) disable iff (!rstn)      // R05
        start_wr |=> (waddr_reg == $past(cmd.addr)))
        else $error("write start address not latched");

    // a back-to-back read every other cycle keeps the indicator up, so exclude it
    a_valid_lead: assert property (@(posedge clock) disable iff (!rstn)      // R17
        (start_rd && !rd2_reg)
        |=> (out_reg.valid_fall && !out_reg.valid_rise && !out_reg.q_oe)
        ##2 (!out_reg.valid_fall || $past(start_rd)))
        else $error("valid indicator not half a cycle ahead of data");

    a_valid_rise_oe: assert property (@(posedge clock) disable iff (!rstn)   // R17
        out_reg.valid_rise |-> out_reg.q_oe)
        else $error("valid indicator up while outputs float");

    a_pending_done: assert property (@(posedge clock) disable iff (!rstn)    // R15
        rd2_reg |=> out_reg.q_oe)
        else $error("pending read pair not driven");

    a_float_hold: assert property (@(posedge clock) disable iff (!rstn)      // R03
        (!rd1_reg && !rd2_reg) |=> $stable(out_reg.q_rise))
        else $error("read word moved without a read");

    a_rd_busy: assert property (@(posedge clock) disable iff (!rstn)         // R08
        rd1_reg |-> !start_rd)
        else $error("read select honoured while the read port is busy");

    a_wr_busy: assert property (@(posedge clock) disable iff (!rstn)         // R08
        wr1_reg |-> !start_wr)
        else $error("write select honoured while the write port is busy");

    a_no_back_read: assert property (@(posedge clock) disable iff (!rstn)    // R09
        start_rd |=> !start_rd)
        else $error("read accepted on consecutive cycles");

    a_no_back_write: assert property (@(posedge clock) disable iff (!rstn)   // R09
        start_wr |=> !start_wr)
        else $error("write accepted on consecutive cycles");

    a_tie_read_first: assert property (@(posedge clock) disable iff (!rstn)  // R16
        (!cmd.read_port_select_n && !cmd.write_port_select_n && !rd1_reg && !wr1_reg)
        |-> (start_rd && !start_wr))
        else $error("idle tie not won by the read");

    a_write_after_rd: assert property (@(posedge clock) disable iff (!rstn)  // R16
        (rd1_reg && !wr1_reg && !cmd.write_port_select_n) |-> start_wr)
        else $error("write lost after a read");

    a_read_after_wr: assert property (@(posedge clock) disable iff (!rstn)   // R16
        (wr1_reg && !rd1_reg && !cmd.read_port_select_n) |-> (start_rd && !start_wr))
        else $error("read lost after a write");

    a_write_phases: assert property (@(posedge clock) disable iff (!rstn)    // R01
        start_wr |=> (wr1_reg && mem_waddr == $past(cmd.addr))
        ##1 (wr2_reg && mem_waddr == $past(waddr_reg) + ADDR_W'(PAIR_STEP)))
        else $error("write data phases out of place");

    a_mask_none: assert property (@(posedge clock) disable iff (!rstn)       // R11 R13
        (wr_active && &wdata.byte_write_select_n_rise) |-> (we_rise == '0))
        else $error("lane written with its select high");

    a_mask_none_fall: assert property (@(posedge clock) disable iff (!rstn)  // R11 R13
        (wr_active && &wdata.byte_write_select_n_fall) |-> (we_fall == '0))
        else $error("fall lane written with its select high");

    a_lane_fall: assert property (@(posedge clock) disable iff (!rstn)       // R06 R10
        (wr_active && !wdata.byte_write_select_n_fall[0]) |-> we_fall[0])
        else $error("fall word lane 0 not written");

    a_no_stray_write: assert property (@(posedge clock) disable iff (!rstn)  // R01
        !wr_active |-> (we_rise == '0 && we_fall == '0))
        else $error("array written outside a write burst");

    a_idle_float: assert property (@(posedge clock) disable iff (!rstn)      // R15
        (!rd1_reg && !rd2_reg) |=> !out_reg.q_oe)
        else $error("outputs driven without a pending read");

    a_reset_float: assert property (@(posedge clock)                        // R04
        !rstn |=> (!out_reg.q_oe && !rd1_reg && !wr1_reg))
        else $error("not deselected after reset");

endmodule

// ### tb/ctrl_model.sv
// controller stand-in that drives commands and write data, one cycle per put_cmd or put_data call
// assumes each call starts just after a rising clock edge
`timescale 1ns/100ps

module ctrl_model
    import burst_sram_pkg::*;
(
    input  wire logic clock,
    output cmd_t      cmd,
    output wdata_t    wdata
);
    initial begin
        cmd   = '{1'b1, 1'b1, '0};
        wdata = '0;
    end

    // one command cycle; the command stays until the next call or idle_cmd
    // so no signal is assigned twice in one time step
    task automatic put_cmd(input logic rd_n, input logic wr_n, input logic [ADDR_W-1:0] a);
        cmd = '{rd_n, wr_n, a};
        @(posedge clock);
        #1;
    endtask

    // both selects high; the address changes pattern so stale values never pass
    task automatic idle_cmd();
        cmd = '{1'b1, 1'b1, ~cmd.addr};
    endtask

    // one data cycle of a write, own lane selects per edge; selects go idle
    task automatic put_data(input wdata_t w);
        cmd   = '{1'b1, 1'b1, ~cmd.addr};
        wdata = w;
        @(posedge clock);
        #1;
    endtask
endmodule

// ### tb/sync_burst4_sram_port_test.sv
// self-checking bench for the burst sram port, default 18-bit organisation
// assumes the package widths; the controller model drives the command and write data inputs
`timescale 1ns/100ps

module sync_burst4_sram_port_test
    import burst_sram_pkg::*;
;
    logic                clock = 1'b0;
    logic                clk_run = 1'b1;
    logic                rstn  = 1'b0;
    cmd_t                cmd;
    wdata_t              wdata;
    rdata_t              rdata;
    logic [WORD_W-1:0]   mem_exp [0:(1<<ADDR_W)-1];
    int                  n_errors = 0;
    int                  samples_checked = 0;
    int                  cycles = 0;

    always #2.5 clock = clk_run ? ~clock : clock;

    burst_sram_port burst_sram_port_inst (.clock(clock), .rstn(rstn), .cmd(cmd),
                                          .wdata(wdata), .rdata(rdata));
    ctrl_model ctrl_model_inst (.clock(clock), .cmd(cmd), .wdata(wdata));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard: whole run needs under 60 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic apply(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
                         input logic [LANES-1:0] s);
        for (int i = 0; i < LANES; i++) begin
            if (!s[i]) begin
                mem_exp[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
            end
        end
    endtask

    task automatic write_burst(input logic [ADDR_W-1:0] a, input wdata_t w0, input wdata_t w1);
        ctrl_model_inst.put_cmd(1'b1, 1'b0, a);
        ctrl_model_inst.put_data(w0);
        ctrl_model_inst.put_data(w1);
        apply(a, w0.d_rise, w0.byte_write_select_n_rise);
        apply(ADDR_W'(a + 1), w0.d_fall, w0.byte_write_select_n_fall);
        apply(ADDR_W'(a + 2), w1.d_rise, w1.byte_write_select_n_rise);
        apply(ADDR_W'(a + 3), w1.d_fall, w1.byte_write_select_n_fall);
    endtask

    // checks a data pair seen just after the edge that ends the cycle
    task automatic check_pair(input logic [ADDR_W-1:0] a);
        check(WORD_W'(rdata.q_oe), WORD_W'(1));
        check(WORD_W'(rdata.valid_rise), WORD_W'(1));
        check(rdata.q_rise, mem_exp[a]);
        check(rdata.q_fall, mem_exp[ADDR_W'(a + 1)]);
    endtask

    task automatic read_burst(input logic [ADDR_W-1:0] a);
        ctrl_model_inst.put_cmd(1'b0, 1'b1, a);
        ctrl_model_inst.idle_cmd();
        check(WORD_W'(rdata.valid_fall), WORD_W'(1));
        tick();
        check_pair(a);
        tick();
        check_pair(ADDR_W'(a + 2));
        check(WORD_W'(rdata.valid_fall), WORD_W'(0));
        tick();
        check(WORD_W'(rdata.q_oe), WORD_W'(0));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check(WORD_W'({rdata.q_oe, rdata.valid_rise, rdata.valid_fall}), WORD_W'(0));
    endtask

    // burst across the top of the address space
    task automatic t_full_wrap();
        write_burst(10'h3fe, '{18'h1a2b3, 18'h04c5d, 2'b00, 2'b00},
                    '{18'h3e6f7, 18'h20819, 2'b00, 2'b00});
        read_burst(10'h3fe);
    endtask

    // lane masks change on every edge, one word fully masked
    task automatic t_masked();
        write_burst(10'h3fe, '{18'h2aaaa, 18'h15555, 2'b10, 2'b11},
                    '{18'h0f0f0, 18'h3c3c3, 2'b01, 2'b00});
        read_burst(10'h3fe);
    endtask

    // second read on the next edge is ignored
    task automatic t_read_twice();
        write_burst(10'h040, '{18'h00111, 18'h00222, 2'b00, 2'b00},
                    '{18'h00333, 18'h00444, 2'b00, 2'b00});
        ctrl_model_inst.put_cmd(1'b0, 1'b1, 10'h040);
        ctrl_model_inst.put_cmd(1'b0, 1'b1, 10'h3fe);
        ctrl_model_inst.idle_cmd();
        check_pair(10'h040);
        repeat (2) tick();
        check(WORD_W'(rdata.q_oe), WORD_W'(0));
    endtask

    // clock parked high in mid-burst: outputs hold, burst resumes after restart
    task automatic t_clock_stop();
        ctrl_model_inst.put_cmd(1'b0, 1'b1, 10'h040);
        ctrl_model_inst.idle_cmd();
        tick();
        clk_run = 1'b0;
        #20;
        check_pair(10'h040);
        clk_run = 1'b1;
        tick();
        check_pair(10'h042);
        tick();
        check(WORD_W'(rdata.q_oe), WORD_W'(0));
    endtask

    // tie from idle goes to read, tie right after a read goes to write
    task automatic t_ties();
        ctrl_model_inst.put_cmd(1'b0, 1'b0, 10'h040);
        ctrl_model_inst.idle_cmd();
        repeat (4) tick();
        read_burst(10'h040);
        ctrl_model_inst.put_cmd(1'b0, 1'b1, 10'h3fe);
        ctrl_model_inst.put_cmd(1'b0, 1'b0, 10'h080);
        check_pair(10'h3fe);
        ctrl_model_inst.put_data('{18'h12345, 18'h23456, 2'b00, 2'b00});
        check_pair(10'h000);
        ctrl_model_inst.put_data('{18'h34567, 18'h05678, 2'b00, 2'b00});
        apply(10'h080, 18'h12345, 2'b00);
        apply(10'h081, 18'h23456, 2'b00);
        apply(10'h082, 18'h34567, 2'b00);
        apply(10'h083, 18'h05678, 2'b00);
        tick();
        read_burst(10'h080);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        #1;
        t_reset();
        rstn = 1'b1;
        tick();
        t_full_wrap();
        t_masked();
        t_read_twice();
        t_clock_stop();
        t_ties();
        stop_test();
    end
endmodule
